// >>> verilog/sfc_pkg.sv
package sfc_pkg;
  // Geometry
  localparam int PAGE_W = 11;
  localparam int BYTE_W = 9;
  localparam int RSV_W = 4;
  localparam int ADDR_BYTES = 3;
  localparam int GROUP_BITS = 8;
  localparam logic [8:0] PAGE_BYTES = 9'h108;
  localparam int BUF_DEPTH = 264;

  // Opcodes
  localparam logic [7:0] OP_CONT_READ = 8'he8;
  localparam logic [7:0] OP_PAGE_READ = 8'hd2;
  localparam logic [7:0] OP_STATUS_READ = 8'hd7;
  localparam logic [7:0] OP_BUF1_READ = 8'hd4;
  localparam logic [7:0] OP_BUF2_READ = 8'hd6;
  localparam logic [7:0] OP_BUF1_WRITE = 8'h84;
  localparam logic [7:0] OP_BUF2_WRITE = 8'h87;
  localparam logic [7:0] OP_XFER1 = 8'h53;
  localparam logic [7:0] OP_XFER2 = 8'h55;
  localparam logic [7:0] OP_CMP1 = 8'h60;
  localparam logic [7:0] OP_CMP2 = 8'h61;
  localparam logic [7:0] OP_PROG_ERASE1 = 8'h83;
  localparam logic [7:0] OP_PROG_ERASE2 = 8'h86;
  localparam logic [7:0] OP_PROG_THRU1 = 8'h82;
  localparam logic [7:0] OP_PROG_THRU2 = 8'h85;
  localparam logic [7:0] OP_REWRITE1 = 8'h58;
  localparam logic [7:0] OP_REWRITE2 = 8'h59;

  // Dummy bytes between address and data on reads
  localparam logic [2:0] DUMMY_ARRAY = 3'h4;
  localparam logic [2:0] DUMMY_BUF = 3'h1;

  // Timing
  localparam int CLK_MHZ = 200;
  localparam int T_BUSY_NS = 200;
  localparam int T_XFR_US = 150;
  localparam int T_EP_MS = 20;
  localparam int BUSY_CYC = (T_BUSY_NS * CLK_MHZ) / 1000;
  localparam int XFR_CYC = T_XFR_US * CLK_MHZ;
  localparam int EP_CYC = T_EP_MS * 1000 * CLK_MHZ;

  // Status byte: ready in bit 7, compare result in bit 6
  localparam int ST_READY = 7;
  localparam int ST_CMP = 6;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } sfc_link_s;

  typedef struct packed {
    logic [RSV_W-1:0] rsv;
    logic [PAGE_W-1:0] page;
    logic [BYTE_W-1:0] byte_addr;
  } sfc_addr_s;

  typedef struct packed {
    logic [PAGE_W-1:0] page;
    logic [2:0] sector;
    logic erase_prog;
    logic xfer;
  } sfc_op_s;
endpackage

// >>> verilog/sfc_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for the serial link pins
module sfc_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// >>> verilog/sfc_core.sv
`timescale 1ns/1ps
// Operation
// - Works in SPI mode 0 and 3
// - Either clock idle level at select
// - Sample serial input on rising clock
// - Busy low within 200 ns
// - Transfer or compare ends in 150 us
// - Erase plus program ends in 20 ms
// - Everything moves in 8-bit groups
// - Reserved address bits are ignored
// - Decode sector from page address
// - E8 D2 D7 read opcodes
// - Address is 4 reserved, 11 page, 9 byte
module sfc_core #(
  parameter int XFR_CYCLES = sfc_pkg::XFR_CYC,
  parameter int EP_CYCLES = sfc_pkg::EP_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial link pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Status
  output logic ready,
  output sfc_pkg::sfc_op_s last_op
);
  typedef enum logic [5:0] {
    SFC_IDLE = 6'h01,
    SFC_OPC = 6'h02,
    SFC_ADDR = 6'h04,
    SFC_DUMMY = 6'h08,
    SFC_DATA = 6'h10,
    SFC_DONE = 6'h20
  } sfc_state_e;

  sfc_pkg::sfc_link_s pin, pin_q;
  sfc_state_e state;
  logic sck_d;
  logic rise, fall, sel_fall, sel_rise;
  logic [2:0] bitn;
  logic [7:0] shreg, opcode, tx;
  logic [1:0] abyte;
  logic [2:0] dcnt;
  sfc_pkg::sfc_addr_s addr;
  logic [7:0] buf1 [sfc_pkg::BUF_DEPTH];
  logic [7:0] buf2 [sfc_pkg::BUF_DEPTH];
  logic [sfc_pkg::BYTE_W-1:0] bptr;
  logic [31:0] timer;
  logic busy, cmp_flag, launch;
  logic [7:0] next_byte;
  logic [2:0] sector;

  sfc_sync #(.W(3), .INIT(3'h4)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({cs_n, sck, si}),
    .q(pin_q)
  );
  assign pin = pin_q;

  ////////////////////////////////////////////////////////////////////////
  // Edge detection on the synchronised pins
  logic cs_d;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sck_d <= pin.sck;
      cs_d <= pin.cs_n;
    end
  end
  // Rising edge taken only while selected; idle level at select is irrelevant
  assign rise = pin.sck & ~sck_d & ~pin.cs_n;
  assign fall = ~pin.sck & sck_d & ~pin.cs_n;
  assign sel_fall = ~pin.cs_n & cs_d;
  assign sel_rise = pin.cs_n & ~cs_d;

  ////////////////////////////////////////////////////////////////////////
  // Sector decode of the addressed page
  always_comb begin
    if (addr.page[10:3] == 8'h00) begin
      sector = 3'h0;
    end else if (addr.page[10:8] == 3'h0) begin
      sector = 3'h1;
    end else if (addr.page[10:8] == 3'h1) begin
      sector = 3'h2;
    end else begin
      sector = {1'b0, addr.page[10:9]} + 3'h2;
    end
  end

  assign next_byte = {shreg[6:0], pin.si};

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= SFC_IDLE;
      bitn <= 3'h0;
      shreg <= 8'h00;
      opcode <= 8'h00;
      abyte <= 2'h0;
      dcnt <= 3'h0;
      addr <= '0;
      bptr <= '0;
    end else if (pin.cs_n) begin
      state <= SFC_IDLE;
      bitn <= 3'h0;
    end else if (sel_fall) begin
      state <= SFC_OPC;
      bitn <= 3'h0;
      abyte <= 2'h0;
    end else if (rise) begin
      shreg <= next_byte;
      bitn <= bitn + 3'h1;
      if (bitn == 3'h7) begin
        case (state)
          SFC_OPC: begin
            opcode <= next_byte;
            state <= (next_byte == sfc_pkg::OP_STATUS_READ) ? SFC_DATA : SFC_ADDR;
          end
          SFC_ADDR: begin
            addr <= {addr[15:0], next_byte};
            abyte <= abyte + 2'h1;
            if (abyte == 2'(sfc_pkg::ADDR_BYTES - 1)) begin
              bptr <= {addr[0], next_byte};
              case (opcode)
                sfc_pkg::OP_CONT_READ, sfc_pkg::OP_PAGE_READ: begin
                  dcnt <= sfc_pkg::DUMMY_ARRAY;
                  state <= SFC_DUMMY;
                end
                sfc_pkg::OP_BUF1_READ, sfc_pkg::OP_BUF2_READ: begin
                  dcnt <= sfc_pkg::DUMMY_BUF;
                  state <= SFC_DUMMY;
                end
                sfc_pkg::OP_BUF1_WRITE, sfc_pkg::OP_BUF2_WRITE,
                sfc_pkg::OP_PROG_THRU1, sfc_pkg::OP_PROG_THRU2: begin
                  state <= SFC_DATA;
                end
                default: begin
                  state <= SFC_DONE;
                end
              endcase
            end
          end
          SFC_DUMMY: begin
            dcnt <= dcnt - 3'h1;
            if (dcnt == 3'h1) begin
              state <= SFC_DATA;
            end
          end
          SFC_DATA: begin
            if (opcode != sfc_pkg::OP_STATUS_READ) begin
              bptr <= (bptr == sfc_pkg::PAGE_BYTES - 9'h1) ? '0 : bptr + 9'h1;
            end
          end
          default: begin
            state <= state;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Buffer writes land on the eighth rising edge of each data byte
  always_ff @(posedge ref_clk) begin
    if (rise && bitn == 3'h7 && state == SFC_DATA) begin
      if (opcode == sfc_pkg::OP_BUF1_WRITE || opcode == sfc_pkg::OP_PROG_THRU1) begin
        buf1[bptr] <= next_byte;
      end
      if (opcode == sfc_pkg::OP_BUF2_WRITE || opcode == sfc_pkg::OP_PROG_THRU2) begin
        buf2[bptr] <= next_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output shifter: changes on falling clock, loaded at each byte start.
  // Array contents are not modelled; array reads return the buffer 1 image.
  always_comb begin
    if (opcode == sfc_pkg::OP_STATUS_READ) begin
      tx = 8'h00;
      tx[sfc_pkg::ST_READY] = ~busy;
      tx[sfc_pkg::ST_CMP] = cmp_flag;
    end else if (opcode == sfc_pkg::OP_BUF2_READ) begin
      tx = buf2[bptr];
    end else begin
      tx = buf1[bptr];
    end
  end

  // Only read commands may drive the output; writes keep it released
  logic rd_op;
  assign rd_op = opcode inside {sfc_pkg::OP_CONT_READ, sfc_pkg::OP_PAGE_READ,
                                sfc_pkg::OP_BUF1_READ, sfc_pkg::OP_BUF2_READ,
                                sfc_pkg::OP_STATUS_READ};

  logic [7:0] out_sh;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_sh <= 8'h00;
      so <= 1'b0;
      so_oe <= 1'b0;
    end else if (pin.cs_n) begin
      so_oe <= 1'b0;
    end else if (state == SFC_DATA && !rd_op) begin
      so_oe <= 1'b0;
    end else if (state == SFC_DATA && (fall || sel_fall) && bitn == 3'h0) begin
      out_sh <= {tx[6:0], 1'b0};
      so <= tx[7];
      so_oe <= 1'b1;
    end else if (state == SFC_DATA && fall) begin
      out_sh <= {out_sh[6:0], 1'b0};
      so <= out_sh[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Internal operation timer and ready/busy
  always_comb begin
    launch = 1'b0;
    if (sel_rise && state == SFC_DONE) begin
      launch = 1'b1;
    end else if (sel_rise && state == SFC_DATA &&
                 (opcode == sfc_pkg::OP_PROG_THRU1 || opcode == sfc_pkg::OP_PROG_THRU2)) begin
      launch = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      ready <= 1'b1;
      timer <= 32'h0;
      cmp_flag <= 1'b0;
      last_op <= '0;
    end else if (launch && !busy) begin
      busy <= 1'b1;
      ready <= 1'b0;
      last_op.page <= addr.page;
      last_op.sector <= sector;
      case (opcode)
        sfc_pkg::OP_XFER1, sfc_pkg::OP_XFER2, sfc_pkg::OP_CMP1, sfc_pkg::OP_CMP2: begin
          timer <= 32'(XFR_CYCLES);
          last_op.xfer <= 1'b1;
          last_op.erase_prog <= 1'b0;
          cmp_flag <= 1'b0;
        end
        default: begin
          timer <= 32'(EP_CYCLES);
          last_op.xfer <= 1'b0;
          last_op.erase_prog <= 1'b1;
        end
      endcase
    end else if (busy) begin
      if (timer <= 32'h1) begin
        busy <= 1'b0;
        ready <= 1'b1;
      end else begin
        timer <= timer - 32'h1;
      end
    end
  end
endmodule

// >>> testbench/sfc_core_monitor.sv
`timescale 1ns/1ps
module sfc_core_monitor #(
  parameter int XFR_CYCLES = 50,
  parameter int EP_CYCLES = 200
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  // Status
  input wire logic ready,
  input wire sfc_pkg::sfc_op_s last_op
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  int low_n;
  int fall_n;
  logic sck_q;
  function automatic logic [2:0] sec(input logic [10:0] p);
    if (p[10:3] == 8'h00) return 3'h0;
    if (p[10:8] == 3'h0) return 3'h1;
    if (p[10:8] == 3'h1) return 3'h2;
    return {1'b0, p[10:9]} + 3'h2;
  endfunction
  ////////////////////////////////////////
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst || ready) begin
      low_n <= 0;
    end else begin
      low_n <= low_n + 1;
    end
  end
  // Raw clock pin is sampled once; the design adds its own sync lag
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sck_q <= 1'b0;
      fall_n <= 0;
    end else begin
      sck_q <= sck;
      fall_n <= (sck_q && !sck) ? 0 : (fall_n < 15 ? fall_n + 1 : fall_n);
    end
  end
  ////////////////////////////////////////
  sequence s_done;
    $rose(ready);
  endsequence
  busy_fast_a: assert property ($fell(ready) |-> $past(cs_n, 2) && !$past(cs_n, 6))
    else $error("ready fell out of step with select rising");
  xfr_len_a: assert property (s_done ##0 last_op.xfer |-> low_n inside {[XFR_CYCLES-1:XFR_CYCLES+3]})
    else $error("transfer busy time wrong");
  ep_len_a: assert property (s_done ##0 !last_op.xfer |-> low_n inside {[EP_CYCLES-1:EP_CYCLES+3]})
    else $error("erase and program busy time wrong");
  busy_lock_a: assert property (!ready && $past(!ready, 3) |-> $stable(last_op))
    else $error("operation replaced while busy");
  sector_map_a: assert property ($changed(last_op) |-> last_op.sector == sec(last_op.page))
    else $error("sector decode wrong");
  oe_select_a: assert property ($rose(so_oe) |-> !cs_n)
    else $error("output enabled while deselected");
  oe_release_a: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
    else $error("output not released after deselect");
  so_edge_a: assert property (so_oe && $past(so_oe) && $changed(so) |-> fall_n <= 6)
    else $error("output changed away from clock fall");
endmodule

// >>> testbench/sfc_host.sv
`timescale 1ns/1ps
module sfc_host (
  // Link to device
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so
);
  logic mode3;
  // Rolling pointer for the periodic page rewrite
  logic [10:0] rw_ptr;
  initial begin
    rw_ptr = 11'h000;
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    mode3 = 1'b0;
  end
  task automatic sel(input logic m);
    mode3 = m;
    sck = m;
    #100 cs_n = 1'b0;
    #250;
  endtask
  // 125 ns bit time keeps every read type within its rate
  // Reads here never cross a page, so no boundary pause is owed
  task automatic xb(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si = d[i];
      #62.5 sck = 1'b1;
      q[i] = so;
      #62.5;
    end
  endtask
  task automatic desel();
    sck = mode3;
    #250 cs_n = 1'b1;
    si = ~si;
    #400;
  endtask
  task automatic hdr(input logic [7:0] op, input logic [10:0] pg, input logic [8:0] ba,
      input logic m);
    logic [23:0] a;
    logic [7:0] q;
    a = {4'h0, pg, ba};
    sel(m);
    xb(op, q);
    for (int i = 2; i >= 0; i--) xb(a[i*8+:8], q);
  endtask
  task automatic rewrite(input logic m);
    hdr(sfc_pkg::OP_REWRITE1, rw_ptr, 9'h000, m);
    rw_ptr = rw_ptr + 11'h1;
  endtask
  // Junk clocking while deselected
  task automatic junk();
    repeat (16) begin
      #60 sck = ~sck;
      si = ~si;
    end
  endtask
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sck, si, so, so_oe, ready;
  sfc_pkg::sfc_op_s last_op;
  int errors = 0;
  int n_compared = 0;
  logic [7:0] q;
  always #2.5 ref_clk = ~ref_clk;
  sfc_core #(.XFR_CYCLES(400), .EP_CYCLES(4000)) dut (.ref_clk(ref_clk), .rst(rst),
    .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe), .ready(ready), .last_op(last_op));
  // A released output reads as its pull-up level
  sfc_host host (.cs_n(cs_n), .sck(sck), .si(si), .so(so_oe ? so : 1'b1));
  ////////////////////////////////////////
  task automatic bad(input string m);
    errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk_b(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) bad("data byte");
  endtask
  task automatic chk_f(input logic g, input logic e);
    n_compared++;
    if (g !== e) bad("flag");
  endtask
  task automatic chk_op(input sfc_pkg::sfc_op_s g, input sfc_pkg::sfc_op_s e);
    n_compared++;
    if (g !== e) bad("operation info");
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    chk_f(ready, 1'b1);
    @(posedge ref_clk);
    #1;
  endtask
  ////////////////////////////////////////
  task automatic t_buf();
    logic [7:0] op [3] = '{sfc_pkg::OP_BUF1_READ, sfc_pkg::OP_CONT_READ, sfc_pkg::OP_PAGE_READ};
    host.hdr(sfc_pkg::OP_BUF1_WRITE, 11'h000, 9'h000, 1'b1);
    host.xb(8'ha5, q);
    host.xb(8'h3c, q);
    host.desel();
    host.junk();
    for (int i = 0; i < 3; i++) begin
      host.hdr(op[i], 11'h000, 9'h000, i[0]);
      repeat (i == 0 ? 1 : 4) host.xb(8'h00, q);
      host.xb(8'h00, q);
      chk_b(q, 8'ha5);
      host.xb(8'h00, q);
      chk_b(q, 8'h3c);
      host.desel();
    end
    $display("t_buf done");
  endtask
  // Buffer 1 was written first, so the 83 entry programs through the buffer
  task automatic t_ops();
    logic [7:0] op [5] = '{sfc_pkg::OP_XFER1, sfc_pkg::OP_PROG_ERASE1, sfc_pkg::OP_XFER2,
      sfc_pkg::OP_PROG_ERASE2, sfc_pkg::OP_CMP1};
    logic [10:0] pg [5] = '{11'h008, 11'h500, 11'h000, 11'h7f8, 11'h200};
    logic [2:0] sc [5] = '{3'h1, 3'h4, 3'h0, 3'h5, 3'h3};
    sfc_pkg::sfc_op_s e;
    for (int i = 0; i < 5; i++) begin
      host.hdr(op[i], pg[i], 9'h000, i[0]);
      host.desel();
      // Program opcodes have the top bit set, transfers and compares do not
      e = '{pg[i], sc[i], op[i][7], !op[i][7]};
      chk_f(ready, 1'b0);
      chk_op(last_op, e);
      wait_rdy();
    end
    // Rewrites follow the host's rolling page pointer
    for (int j = 0; j < 2; j++) begin
      e = '{11'(j), 3'h0, 1'b1, 1'b0};
      host.rewrite(j[0]);
      host.desel();
      chk_op(last_op, e);
      wait_rdy();
    end
    $display("t_ops done");
  endtask
  task automatic t_status();
    host.hdr(sfc_pkg::OP_PROG_THRU1, 11'h100, 9'h000, 1'b0);
    host.xb(8'h5a, q);
    host.desel();
    chk_op(last_op, '{11'h100, 3'h2, 1'b1, 1'b0});
    host.hdr(sfc_pkg::OP_XFER1, 11'h3ff, 9'h000, 1'b1);
    host.desel();
    chk_f(last_op.xfer, 1'b0);
    for (int k = 0; k < 2; k++) begin
      host.sel(k[0]);
      host.xb(sfc_pkg::OP_STATUS_READ, q);
      host.xb(8'h00, q);
      host.desel();
      chk_f(q[sfc_pkg::ST_READY], k[0]);
      wait_rdy();
    end
    $display("t_status done");
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    t_buf();
    t_ops();
    t_status();
    results();
  end
  initial begin
    #400000;
    bad("watchdog expired");
    results();
  end
endmodule
bind sfc_core sfc_core_monitor #(.XFR_CYCLES(XFR_CYCLES), .EP_CYCLES(EP_CYCLES)) mon (
  .ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
  .so_oe(so_oe), .ready(ready), .last_op(last_op));
